// file: hdl/sbp_pkg.sv
package sbp_pkg;
  localparam logic [7:0] SBP_OFS_HOMING = 8'h24;
  localparam logic [7:0] SBP_OFS_POLARITY = 8'h25;
  localparam logic [7:0] SBP_OFS_ALLOC = 8'h26;
  localparam logic [7:0] SBP_OFS_REFERENCE = 8'h27;
  localparam logic [15:0] SBP_RESET_VALUE = 16'h0000;
  // writable bit masks; unused bits stay zero
  localparam logic [15:0] SBP_MASK_HOMING = 16'h7fff;
  localparam logic [15:0] SBP_MASK_POLARITY = 16'hffdf;
  localparam logic [15:0] SBP_MASK_ALLOC = 16'hffff;
  localparam logic [15:0] SBP_MASK_REFERENCE = 16'h1fff;
  localparam logic [3:0] SBP_PCOUNT_MAX = 4'h5;
  localparam logic [2:0] SBP_HMETHOD_MAX = 3'h6;
  localparam logic [3:0] SBP_ALLOC_MAX = 4'h8;
  localparam logic [1:0] SBP_SPECIAL_MAX = 2'h1;

  typedef enum logic [1:0] {
    SBP_SW_TORQUE = 2'h0,
    SBP_SW_SPEED = 2'h1,
    SBP_SW_ACCEL = 2'h2,
    SBP_SW_ERROR = 2'h3
  } sbp_switch_type;

  typedef struct packed {
    logic [3:0] reverse_cap;
    logic [3:0] forward_cap;
    logic [3:0] proportional;
    logic [3:0] servo_on;
    logic [3:0] fault_clear;
  } sbp_alloc_type;

  typedef struct packed {
    logic start_from_current;
    sbp_switch_type switch_sel;
    logic echo_text_en;
    logic ack_reply_en;
    logic error_reply_en;
    logic ignore_no_axis;
    logic [3:0] pulse_count_check;
    logic pulse_train_ref;
    logic absolute_encoder;
    logic alt_homing_method;
    logic homing_minus_dir;
    logic external_step;
    logic use_allocation;
    logic ignore_parity;
    logic complete_width_mult;
    logic complete_signal_en;
    logic buffered_ref;
    logic overwrite_ref;
    logic zero_from_external;
    logic [2:0] homing_method;
  } sbp_cfg_type;

  // raw drive signals, active high, before polarity handling
  typedef struct packed {
    logic current_limit_detect_out;
    logic positioning_complete_out;
    logic brake_release_out;
    logic fault_indicator_out;
  } sbp_out_type;

  typedef struct packed {
    logic home_slowdown_switch_in;
    logic fault_clear_in;
    logic travel_limit_in;
    logic servo_on_in;
    logic manual_step_in;
    logic encoder_index_phase;
    logic external_zero_mark_in;
  } sbp_in_type;
endpackage : sbp_pkg

// file: hdl/sbp_bank.sv
`timescale 1ns/1ps
module sbp_bank
  import sbp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_wr_en,
  input wire logic [7:0] i_addr,
  input wire logic [15:0] i_wr_data,
  output logic [15:0] o_rd_data,
  output logic o_wr_rejected,
  input wire sbp_out_type i_drive_out,
  input wire sbp_in_type i_pins_in,
  output sbp_out_type o_pins_out,
  output sbp_in_type o_drive_in,
  output logic o_homing_marker,
  output logic o_step_from_pin,
  output sbp_cfg_type o_cfg,
  output sbp_alloc_type o_alloc
);

  logic [15:0] homing_r;
  logic [15:0] polarity_r;
  logic [15:0] alloc_r;
  logic [15:0] reference_r;
  logic [15:0] rd_r;
  logic rej_r;

  function automatic logic alloc_ok(input logic [15:0] w);
    alloc_ok = (w[15:12] <= SBP_ALLOC_MAX) && (w[11:8] <= SBP_ALLOC_MAX)
      && (w[7:4] <= SBP_ALLOC_MAX) && (w[3:0] <= SBP_ALLOC_MAX);
  endfunction : alloc_ok

  wire sel_hom = i_addr == SBP_OFS_HOMING;
  wire sel_pol = i_addr == SBP_OFS_POLARITY;
  wire sel_all = i_addr == SBP_OFS_ALLOC;
  wire sel_ref = i_addr == SBP_OFS_REFERENCE;
  // out-of-range codes refused, word unchanged
  wire ok_hom = i_wr_data[7:4] <= SBP_PCOUNT_MAX;
  wire ok_pol = i_wr_data[7:6] <= SBP_SPECIAL_MAX;
  wire ok_all = alloc_ok(i_wr_data);
  wire ok_ref = (i_wr_data[6:4] <= SBP_HMETHOD_MAX)
    && (i_wr_data[3:0] <= SBP_ALLOC_MAX);
  wire wr_hom = i_wr_en && sel_hom && ok_hom;
  wire wr_pol = i_wr_en && sel_pol && ok_pol;
  wire wr_all = i_wr_en && sel_all && ok_all;
  wire wr_ref = i_wr_en && sel_ref && ok_ref;
  wire sel_any = sel_hom || sel_pol || sel_all || sel_ref;
  wire wr_any = wr_hom || wr_pol || wr_all || wr_ref;
  wire rej_nxt = i_wr_en && !wr_any;

  wire [15:0] hom_nxt = wr_hom ? (i_wr_data & SBP_MASK_HOMING) : homing_r;
  wire [15:0] pol_nxt = wr_pol ? (i_wr_data & SBP_MASK_POLARITY)
    : polarity_r;
  wire [15:0] all_nxt = wr_all ? (i_wr_data & SBP_MASK_ALLOC) : alloc_r;
  wire [15:0] ref_nxt = wr_ref ? (i_wr_data & SBP_MASK_REFERENCE)
    : reference_r;
  wire [15:0] rd_nxt = sel_hom ? homing_r :
    sel_pol ? polarity_r :
    sel_all ? alloc_r :
    sel_ref ? reference_r : 16'h0000;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      homing_r <= SBP_RESET_VALUE;
      polarity_r <= SBP_RESET_VALUE;
      alloc_r <= SBP_RESET_VALUE;
      reference_r <= SBP_RESET_VALUE;
      rd_r <= 16'h0000;
      rej_r <= 1'b0;
    end else begin
      homing_r <= hom_nxt;
      polarity_r <= pol_nxt;
      alloc_r <= all_nxt;
      reference_r <= ref_nxt;
      rd_r <= rd_nxt;
      rej_r <= rej_nxt;
    end
  end

  assign o_rd_data = rd_r;
  assign o_wr_rejected = rej_r;

  // first word fields
  assign o_cfg.start_from_current = homing_r[14];
  assign o_cfg.switch_sel = sbp_switch_type'(homing_r[13:12]);
  assign o_cfg.echo_text_en = homing_r[11];
  assign o_cfg.ack_reply_en = homing_r[10];
  assign o_cfg.error_reply_en = homing_r[9];
  assign o_cfg.ignore_no_axis = homing_r[8];
  assign o_cfg.pulse_count_check = homing_r[7:4];
  assign o_cfg.pulse_train_ref = homing_r[3];
  assign o_cfg.absolute_encoder = homing_r[2];
  assign o_cfg.alt_homing_method = homing_r[1];
  assign o_cfg.homing_minus_dir = homing_r[0];
  // second and fourth word fields
  assign o_cfg.external_step = polarity_r[2];
  assign o_cfg.use_allocation = polarity_r[6];
  assign o_cfg.ignore_parity = reference_r[12];
  assign o_cfg.complete_width_mult = reference_r[11];
  assign o_cfg.complete_signal_en = reference_r[10];
  assign o_cfg.buffered_ref = reference_r[9];
  assign o_cfg.overwrite_ref = reference_r[8];
  assign o_cfg.zero_from_external = reference_r[7];
  assign o_cfg.homing_method = reference_r[6:4];

  // allocation codes only count in allocated mode
  wire alloc_on = polarity_r[6];
  assign o_alloc.reverse_cap = alloc_on ? alloc_r[15:12] : 4'h0;
  assign o_alloc.forward_cap = alloc_on ? alloc_r[11:8] : 4'h0;
  assign o_alloc.proportional = alloc_on ? alloc_r[7:4] : 4'h0;
  assign o_alloc.servo_on = alloc_on ? alloc_r[3:0] : 4'h0;
  assign o_alloc.fault_clear = alloc_on ? reference_r[3:0] : 4'h0;

  // output path: mask forces inactive, then invert
  wire [3:0] raw_out = i_drive_out;
  wire [3:0] masked_out = raw_out & ~polarity_r[11:8];
  assign o_pins_out = masked_out ^ polarity_r[15:12];

  // input path
  assign o_drive_in.home_slowdown_switch_in =
    i_pins_in.home_slowdown_switch_in ^ polarity_r[4];
  assign o_drive_in.fault_clear_in =
    i_pins_in.fault_clear_in & ~polarity_r[3];
  assign o_drive_in.travel_limit_in =
    i_pins_in.travel_limit_in & ~polarity_r[1];
  assign o_drive_in.servo_on_in =
    i_pins_in.servo_on_in & ~polarity_r[0];
  assign o_drive_in.manual_step_in =
    i_pins_in.manual_step_in & polarity_r[2];
  assign o_drive_in.encoder_index_phase = i_pins_in.encoder_index_phase;
  assign o_drive_in.external_zero_mark_in = i_pins_in.external_zero_mark_in;
  assign o_homing_marker = reference_r[7] ? i_pins_in.external_zero_mark_in
    : i_pins_in.encoder_index_phase;
  assign o_step_from_pin = polarity_r[2];

  property p_reset_zero;
    @(posedge i_clk) i_rst |=> (homing_r == 16'h0000)
      && (reference_r == 16'h0000) && (polarity_r == 16'h0000)
      && (alloc_r == 16'h0000) && (o_rd_data == 16'h0000) && !o_wr_rejected;
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("word not zero after reset");

  property p_unused_zero;
    @(posedge i_clk) disable iff (i_rst)
      !homing_r[15] && !polarity_r[5] && (reference_r[15:13] == 3'h0);
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("unused bit set");

  property p_pcount_range;
    @(posedge i_clk) disable iff (i_rst)
      homing_r[7:4] <= SBP_PCOUNT_MAX;
  endproperty
  a_pcount_range: assert property (p_pcount_range)
    else $error("pulse count code out of range");

  property p_hmethod_range;
    @(posedge i_clk) disable iff (i_rst)
      o_cfg.homing_method <= SBP_HMETHOD_MAX;
  endproperty
  a_hmethod_range: assert property (p_hmethod_range)
    else $error("homing method out of range");

  property p_alloc_range;
    @(posedge i_clk) disable iff (i_rst) alloc_ok(alloc_r)
      && (reference_r[3:0] <= SBP_ALLOC_MAX);
  endproperty
  a_alloc_range: assert property (p_alloc_range)
    else $error("allocation code out of range");

  sequence s_write_home;
    i_wr_en && sel_hom && ok_hom;
  endsequence
  property p_write_home;
    @(posedge i_clk) disable iff (i_rst)
      s_write_home |=> (o_cfg.homing_minus_dir == $past(i_wr_data[0]))
      && (o_cfg.start_from_current == $past(i_wr_data[14]));
  endproperty
  a_write_home: assert property (p_write_home)
    else $error("homing word write not applied");

  property p_out_polarity;
    @(posedge i_clk) disable iff (i_rst)
      o_pins_out == ((i_drive_out & ~polarity_r[11:8]) ^ polarity_r[15:12]);
  endproperty
  a_out_polarity: assert property (p_out_polarity)
    else $error("output mask or inversion wrong");

  property p_slowdown;
    @(posedge i_clk) disable iff (i_rst)
      polarity_r[4] |-> o_drive_in.home_slowdown_switch_in
        != i_pins_in.home_slowdown_switch_in;
  endproperty
  a_slowdown: assert property (p_slowdown)
    else $error("slowdown switch not inverted");

  property p_masks;
    @(posedge i_clk) disable iff (i_rst)
      polarity_r[0] |-> !o_drive_in.servo_on_in && (polarity_r[3]
        ? !o_drive_in.fault_clear_in : 1'b1);
  endproperty
  a_masks: assert property (p_masks)
    else $error("input mask not applied");

  property p_marker;
    @(posedge i_clk) disable iff (i_rst) !reference_r[7] |->
      o_homing_marker == i_pins_in.encoder_index_phase;
  endproperty
  a_marker: assert property (p_marker)
    else $error("homing marker source wrong");

  property p_read_back;
    @(posedge i_clk) disable iff (i_rst)
      (sel_ref && !i_wr_en) |=> o_rd_data == $past(reference_r);
  endproperty
  a_read_back: assert property (p_read_back)
    else $error("read data wrong");

  property p_reject_pcount;
    @(posedge i_clk) disable iff (i_rst)
      (i_wr_en && sel_hom && (i_wr_data[7:4] > SBP_PCOUNT_MAX))
        |=> o_wr_rejected && $stable(homing_r);
  endproperty
  a_reject_pcount: assert property (p_reject_pcount)
    else $error("bad pulse count code not refused");

  property p_reject_special;
    @(posedge i_clk) disable iff (i_rst)
      (i_wr_en && sel_pol && (i_wr_data[7:6] > SBP_SPECIAL_MAX))
        |=> o_wr_rejected && $stable(polarity_r);
  endproperty
  a_reject_special: assert property (p_reject_special)
    else $error("bad special input code not refused");

  property p_reject_method;
    @(posedge i_clk) disable iff (i_rst)
      (i_wr_en && sel_ref && (i_wr_data[6:4] > SBP_HMETHOD_MAX))
        |=> o_wr_rejected && $stable(reference_r);
  endproperty
  a_reject_method: assert property (p_reject_method)
    else $error("bad homing method code not refused");

  property p_switch_sel;
    @(posedge i_clk) disable iff (i_rst)
      s_write_home |=> o_cfg.switch_sel == $past(i_wr_data[13:12]);
  endproperty
  a_switch_sel: assert property (p_switch_sel)
    else $error("mode switch selection not applied");

  property p_reply_enables;
    @(posedge i_clk) disable iff (i_rst)
      s_write_home |=> ({o_cfg.echo_text_en, o_cfg.ack_reply_en,
        o_cfg.error_reply_en} == $past(i_wr_data[11:9]));
  endproperty
  a_reply_enables: assert property (p_reply_enables)
    else $error("reply enables not applied");

  property p_axis_ignore;
    @(posedge i_clk) disable iff (i_rst)
      s_write_home |=> o_cfg.ignore_no_axis == $past(i_wr_data[8]);
  endproperty
  a_axis_ignore: assert property (p_axis_ignore)
    else $error("axis ignore bit not applied");

  property p_pulse_train;
    @(posedge i_clk) disable iff (i_rst)
      s_write_home |=> o_cfg.pulse_train_ref == $past(i_wr_data[3]);
  endproperty
  a_pulse_train: assert property (p_pulse_train)
    else $error("pulse train bit not applied");

  sequence s_write_ref;
    i_wr_en && sel_ref && ok_ref;
  endsequence
  property p_complete_width;
    @(posedge i_clk) disable iff (i_rst)
      s_write_ref |=> o_cfg.complete_width_mult == $past(i_wr_data[11]);
  endproperty
  a_complete_width: assert property (p_complete_width)
    else $error("completion width multiplier not applied");

  property p_complete_signal;
    @(posedge i_clk) disable iff (i_rst)
      s_write_ref |=> o_cfg.complete_signal_en == $past(i_wr_data[10]);
  endproperty
  a_complete_signal: assert property (p_complete_signal)
    else $error("completion signal enable not applied");

  property p_ref_handling;
    @(posedge i_clk) disable iff (i_rst)
      s_write_ref |=> ({o_cfg.buffered_ref, o_cfg.overwrite_ref}
        == $past(i_wr_data[9:8]));
  endproperty
  a_ref_handling: assert property (p_ref_handling)
    else $error("reference handling bits not applied");

  property p_parity;
    @(posedge i_clk) disable iff (i_rst)
      s_write_ref |=> o_cfg.ignore_parity == $past(i_wr_data[12]);
  endproperty
  a_parity: assert property (p_parity)
    else $error("ignore parity bit not applied");

endmodule : sbp_bank

// file: test/tb.sv
`timescale 1ns/1ps
module tb;
  import sbp_pkg::*;
  typedef struct packed {
    logic [3:0] id;
    logic [31:0] exp;
  } sbp_note_type;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_wr_en = 1'b0;
  logic [7:0] i_addr = 8'h24;
  logic [15:0] i_wr_data = 16'h0000;
  logic [15:0] o_rd_data;
  logic o_wr_rejected;
  sbp_out_type i_drive_out = '0;
  sbp_in_type i_pins_in = '0;
  sbp_out_type o_pins_out;
  sbp_in_type o_drive_in;
  logic o_homing_marker;
  logic o_step_from_pin;
  sbp_cfg_type o_cfg;
  sbp_alloc_type o_alloc;
  int fail_count = 0;
  int n_compared = 0;
  integer seed = 63;
  logic [15:0] w [4] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
  // word numbers in hex, two unmapped
  logic [7:0] tbl [8] = '{8'h24, 8'h25, 8'h26, 8'h27, 8'h24, 8'h27, 8'h23,
                          8'h28};
  sbp_note_type q [$];
  sbp_note_type n;
  string nm [8] = '{"rd_data", "wr_rejected", "pins_out", "drive_in",
                    "homing_marker", "step_from_pin", "cfg", "alloc"};

  always #5 i_clk = ~i_clk;

  sbp_bank dut (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_wr_en(i_wr_en),
    .i_addr(i_addr),
    .i_wr_data(i_wr_data),
    .o_rd_data(o_rd_data),
    .o_wr_rejected(o_wr_rejected),
    .i_drive_out(i_drive_out),
    .i_pins_in(i_pins_in),
    .o_pins_out(o_pins_out),
    .o_drive_in(o_drive_in),
    .o_homing_marker(o_homing_marker),
    .o_step_from_pin(o_step_from_pin),
    .o_cfg(o_cfg),
    .o_alloc(o_alloc)
  );

  function automatic logic [31:0] got(input logic [3:0] id);
    case (id)
      4'h0: got = {16'h0000, o_rd_data};
      4'h1: got = {31'h0, o_wr_rejected};
      4'h2: got = {28'h0, o_pins_out};
      4'h3: got = {25'h0, o_drive_in};
      4'h4: got = {31'h0, o_homing_marker};
      4'h5: got = {31'h0, o_step_from_pin};
      4'h6: got = {6'h00, o_cfg};
      default: got = {12'h000, o_alloc};
    endcase
  endfunction : got

  function automatic logic legal(input logic [7:0] a, input logic [15:0] d);
    case (a)
      8'h24: legal = d[7:4] <= 4'h5;
      8'h25: legal = d[7:6] <= 2'h1;
      8'h26: legal = d[15:12] <= 4'h8 && d[11:8] <= 4'h8 &&
                     d[7:4] <= 4'h8 && d[3:0] <= 4'h8;
      8'h27: legal = d[6:4] <= 3'h6 && d[3:0] <= 4'h8;
      default: legal = 1'b0;
    endcase
  endfunction : legal

  function automatic logic [15:0] msk(input logic [7:0] a);
    case (a)
      8'h24: msk = 16'h7fff;
      8'h25: msk = 16'hffdf;
      8'h27: msk = 16'h1fff;
      default: msk = 16'hffff;
    endcase
  endfunction : msk

  function automatic logic [15:0] rd_exp(input logic [7:0] a);
    rd_exp = (a >= 8'h24 && a <= 8'h27) ? w[a[1:0]] : 16'h0000;
  endfunction : rd_exp

  task cmp_rd(input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] rd_data expected %h seen %h", e, g);
    end
  endtask : cmp_rd

  task cmp_rej(input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] wr_rejected expected %h seen %h", e, g);
    end
  endtask : cmp_rej

  task cmp_out(input logic [3:0] id, input logic [31:0] e,
               input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm[id], e, g);
    end
  endtask : cmp_out

  task note(input logic [3:0] id, input logic [31:0] e);
    q.push_back(sbp_note_type'{id, e});
  endtask : note

  // results checked one step after the edge that follows the notes
  always @(posedge i_clk) begin
    #1;
    while (q.size() > 0) begin
      n = q.pop_front();
      case (n.id)
        4'h0: cmp_rd(n.exp[15:0], o_rd_data);
        4'h1: cmp_rej(n.exp[0], o_wr_rejected);
        default: cmp_out(n.id, n.exp, got(n.id));
      endcase
    end
  end

  task comb_notes;
    logic [25:0] c;
    sbp_in_type p;
    p = i_pins_in;
    c = {w[0][14:0], w[1][2], w[1][6], w[3][12:4]};
    note(4'h2, {28'h0, (i_drive_out & ~w[1][11:8]) ^ w[1][15:12]});
    note(4'h3, {25'h0, p.home_slowdown_switch_in ^ w[1][4],
                p.fault_clear_in & ~w[1][3], p.travel_limit_in & ~w[1][1],
                p.servo_on_in & ~w[1][0], p.manual_step_in & w[1][2],
                p.encoder_index_phase, p.external_zero_mark_in});
    note(4'h4, {31'h0, w[3][7] ? p.external_zero_mark_in :
                p.encoder_index_phase});
    note(4'h5, {31'h0, w[1][2]});
    note(4'h6, {6'h00, c});
    note(4'h7, {12'h000, w[1][6] ? {w[2], w[3][3:0]} : 20'h0});
  endtask : comb_notes

  task rd(input logic [7:0] a);
    @(negedge i_clk);
    i_addr = a;
    note(4'h0, {16'h0000, rd_exp(a)});
  endtask : rd

  task wr(input logic [7:0] a, input logic [15:0] d);
    logic ok;
    logic [31:0] r;
    ok = legal(a, d);
    r = $random(seed);
    @(negedge i_clk);
    i_wr_en = 1'b1;
    i_addr = a;
    i_wr_data = d;
    i_drive_out = r[3:0];
    i_pins_in = r[10:4];
    note(4'h1, {31'h0, ~ok});
    if (ok) begin
      w[a[1:0]] = d & msk(a);
    end
    @(negedge i_clk);
    i_wr_en = 1'b0;
    note(4'h1, 32'h0);
    note(4'h0, {16'h0000, rd_exp(a)});
    comb_notes();
  endtask : wr

  task report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    #100000;
    fail_count++;
    report_and_stop();
  end

  initial begin
    logic [31:0] r;
    logic [15:0] d;
    repeat (6) @(posedge i_clk);
    @(negedge i_clk);
    i_rst = 1'b0;
    for (int k = 0; k < 8; k++) begin
      rd(tbl[k]);
    end
    $display("test reset_values done");
    for (int i = 0; i < 300; i++) begin
      r = $random(seed);
      d = $random(seed);
      if (r[4:3] != 2'h0) begin
        d = d & 16'h7777;
      end
      wr(tbl[r[2:0]], d);
    end
    $display("test random_writes done");
    @(negedge i_clk);
    i_rst = 1'b1;
    @(negedge i_clk);
    i_rst = 1'b0;
    w = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
    comb_notes();
    for (int k = 0; k < 4; k++) begin
      rd(tbl[k]);
    end
    @(negedge i_clk);
    $display("test mid_reset done");
    report_and_stop();
  end
endmodule : tb
